/* core/jsd_job_select.sv */
// Contract
// - with the two-job function on an input, low runs job one and high runs job two.
// - in binary mode up to five inputs mapped as job bits form a job number among up to 31.
// - in binary mode a switch starts as soon as the job-bit pattern changes.
// - the shown active job updates only at the first trigger after a switch.
// - every physical input takes any select function through a programmable map.
// - pulses on the pulse-count input are accepted only while ready is high.
// - pulses are counted until a quiet gap of 50 ms, then the job equal to the count is chosen if the count is at most njobs.
// - ready goes low 50 ms after the last counted pulse when the count is at most njobs; a larger count leaves ready high.
// - ready stays low until the switch-over to the new job has completed.
// - in pulse mode with confirmation enabled, confirm rises after the change and only then ready returns.
`timescale 1ns/1ps
`default_nettype none

module jsd_job_select #(
   parameter int unsigned GAP_CYCLES = jsd_pkg::GAP_CYCLES,
   parameter int unsigned CONF_CYCLES = jsd_pkg::CONF_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] din_i,
   input wire logic trigger_i,
   input wire logic job_loaded_i,
   output logic [4:0] job_num_o,
   output logic job_load_o,
   output logic ready_o,
   output logic confirm_o,
   output logic busy_o,
   output logic [4:0] active_job_o,
   output logic [4:0] shown_job_o
);

   localparam logic [23:0] GAP_LAST = 24'(GAP_CYCLES - 1);
   localparam logic [23:0] CONF_LAST = 24'(CONF_CYCLES - 1);

   jsd_pkg::jsd_state_t s_reg;
   jsd_pkg::jsd_state_t s_next;

   // one level per function: or of all inputs mapped to it
   logic [jsd_pkg::NUM_FN-1:0] fn_level;
   logic [jsd_pkg::NUM_FN*jsd_pkg::NUM_INPUTS-1:0] fn_hit;

   genvar gf;
   genvar gi;
   generate
      for (gf = 0; gf < jsd_pkg::NUM_FN; gf++) begin : g_fn
         for (gi = 0; gi < jsd_pkg::NUM_INPUTS; gi++) begin : g_in
            // any input may carry any function
            assign fn_hit[gf*jsd_pkg::NUM_INPUTS+gi] = din_i[gi] &&
               (s_reg.map[gi*jsd_pkg::FN_W +: jsd_pkg::FN_W] == jsd_pkg::FN_W'(gf));
         end
         assign fn_level[gf] = |fn_hit[gf*jsd_pkg::NUM_INPUTS +: jsd_pkg::NUM_INPUTS];
      end
   endgenerate

   logic [4:0] bin_val;
   logic job12_level;
   logic pulse_level;
   logic bus_req;
   logic [31:0] wmask;
   logic [31:0] status_word;
   logic [31:0] ctrl_word;

   // bit x sits on function code FN_BIT0 + x, so its weight is two to the x
   assign bin_val = fn_level[int'(jsd_pkg::FN_BIT0) +: jsd_pkg::JOB_BITS];
   assign job12_level = fn_level[int'(jsd_pkg::FN_JOB12)];
   assign pulse_level = fn_level[int'(jsd_pkg::FN_PULSE)];
   assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[jsd_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
      ctrl_word[jsd_pkg::CTRL_CONF_BIT] = s_reg.conf_en;
      ctrl_word[jsd_pkg::CTRL_NJOBS_LSB +: 5] = s_reg.njobs;
      status_word = 32'h0000_0000;
      status_word[jsd_pkg::STAT_ACTIVE_LSB +: 5] = s_reg.active;
      status_word[jsd_pkg::STAT_SHOWN_LSB +: 5] = s_reg.shown;
      status_word[jsd_pkg::STAT_READY_BIT] = (s_reg.pstate == jsd_pkg::PS_COUNT);
      status_word[jsd_pkg::STAT_BUSY_BIT] = s_reg.busy;
      status_word[jsd_pkg::STAT_CONF_BIT] = s_reg.confirm;
   end

   always_comb begin
      logic [4:0] cand;
      logic want;
      logic [31:0] wr_ctrl;
      cand = 5'h00;
      want = 1'b0;
      wr_ctrl = 32'h0000_0000;
      s_next = s_reg;
      s_next.load = 1'b0;

      // wishbone classic: ack one cycle after the strobe, dropped the next cycle
      s_next.ack = bus_req;
      if (bus_req) begin
         case (wb_adr_i)
            jsd_pkg::ADDR_CTRL: s_next.rdata = ctrl_word;
            jsd_pkg::ADDR_MAP: s_next.rdata = s_reg.map;
            jsd_pkg::ADDR_STATUS: s_next.rdata = status_word;
            default: s_next.rdata = 32'h0000_0000;
         endcase
         if (wb_we_i) begin
            case (wb_adr_i)
               jsd_pkg::ADDR_CTRL: begin
                  wr_ctrl = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
                  s_next.mode = wr_ctrl[jsd_pkg::CTRL_MODE_LSB +: 2];
                  s_next.conf_en = wr_ctrl[jsd_pkg::CTRL_CONF_BIT];
                  s_next.njobs = wr_ctrl[jsd_pkg::CTRL_NJOBS_LSB +: 5];
               end
               jsd_pkg::ADDR_MAP: begin
                  s_next.map = (s_reg.map & ~wmask) | (wb_dat_i & wmask);
               end
               default: begin
               end
            endcase
         end
      end

      // job loader answers a load; the new job becomes active then
      if (s_reg.busy && job_loaded_i) begin
         s_next.busy = 1'b0;
         s_next.active = s_reg.job_num;
         s_next.disp_pend = 1'b1;
      end

      // displayed job waits for the first trigger after the switch
      if (trigger_i && s_reg.disp_pend && !s_reg.busy) begin
         s_next.shown = s_reg.active;
         s_next.disp_pend = 1'b0;
      end

      s_next.prev_pulse = pulse_level;

      case (s_reg.mode)
         jsd_pkg::MODE_TWO_JOB: begin
            cand = job12_level ? jsd_pkg::JOB_SECOND : jsd_pkg::JOB_FIRST;
            want = (cand != s_reg.job_num) && !s_reg.busy;
         end
         jsd_pkg::MODE_BINARY: begin
            // a pattern change starts a switch at once; no trigger needed
            if (!s_reg.busy && bin_val != s_reg.pat) begin
               s_next.pat = bin_val;
               cand = bin_val;
               // zero or an unstored job is ignored
               want = (bin_val != 5'h00) && (bin_val <= s_reg.njobs);
            end
         end
         jsd_pkg::MODE_PULSE: begin
            case (s_reg.pstate)
               jsd_pkg::PS_COUNT: begin
                  // edges count only while ready is high, i.e. in this state
                  if (pulse_level && !s_reg.prev_pulse) begin
                     if (s_reg.cnt != jsd_pkg::JOB_COUNT_MAX) begin
                        s_next.cnt = s_reg.cnt + 5'h01;
                     end
                     s_next.timer = 24'h00_0000;
                  end else if (s_reg.cnt != 5'h00) begin
                     if (s_reg.timer == GAP_LAST) begin
                        // quiet gap seen: ready falls now, 50 ms after the last pulse, if the count is at most njobs
                        s_next.timer = 24'h00_0000;
                        s_next.cnt = 5'h00;
                        if (s_reg.cnt <= s_reg.njobs && !s_reg.busy) begin
                           cand = s_reg.cnt;
                           want = 1'b1;
                           s_next.pstate = jsd_pkg::PS_SWITCH;
                        end
                     end else begin
                        s_next.timer = s_reg.timer + 24'h00_0001;
                     end
                  end
               end
               jsd_pkg::PS_SWITCH: begin
                  // ready held low until the loader reports completion
                  if (job_loaded_i) begin
                     s_next.timer = 24'h00_0000;
                     s_next.pstate = s_reg.conf_en ? jsd_pkg::PS_CONFIRM : jsd_pkg::PS_COUNT;
                     s_next.confirm = s_reg.conf_en;
                  end
               end
               jsd_pkg::PS_CONFIRM: begin
                  // ready returns only once the confirm pulse is over
                  if (s_reg.timer == CONF_LAST) begin
                     s_next.confirm = 1'b0;
                     s_next.timer = 24'h00_0000;
                     s_next.pstate = jsd_pkg::PS_COUNT;
                  end else begin
                     s_next.timer = s_reg.timer + 24'h00_0001;
                  end
               end
               default: s_next.pstate = jsd_pkg::PS_COUNT;
            endcase
         end
         default: begin
         end
      endcase

      // leaving pulse mode drops any half-counted burst
      if (s_reg.mode != jsd_pkg::MODE_PULSE && s_reg.pstate != jsd_pkg::PS_SWITCH) begin
         s_next.pstate = jsd_pkg::PS_COUNT;
         s_next.cnt = 5'h00;
         s_next.timer = 24'h00_0000;
         s_next.confirm = 1'b0;
      end

      if (want) begin
         s_next.job_num = cand;
         s_next.load = 1'b1;
         s_next.busy = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg <= '{
            ack: 1'b0,
            rdata: 32'h0000_0000,
            mode: jsd_pkg::CTRL_MODE_RST,
            conf_en: jsd_pkg::CTRL_CONF_RST,
            njobs: jsd_pkg::CTRL_NJOBS_RST,
            map: jsd_pkg::MAP_RST,
            pat: 5'h00,
            prev_pulse: 1'b0,
            cnt: 5'h00,
            timer: 24'h00_0000,
            pstate: jsd_pkg::PS_COUNT,
            busy: 1'b0,
            confirm: 1'b0,
            job_num: jsd_pkg::JOB_FIRST,
            load: 1'b0,
            active: jsd_pkg::JOB_FIRST,
            shown: jsd_pkg::JOB_FIRST,
            disp_pend: 1'b0
         };
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_o = s_reg.rdata;
   assign wb_ack_o = s_reg.ack;
   assign job_num_o = s_reg.job_num;
   assign job_load_o = s_reg.load;
   assign ready_o = (s_reg.pstate == jsd_pkg::PS_COUNT);
   assign confirm_o = s_reg.confirm;
   assign busy_o = s_reg.busy;
   assign active_job_o = s_reg.active;
   assign shown_job_o = s_reg.shown;

endmodule

`default_nettype wire

/* core/jsd_pkg.sv */
package jsd_pkg;

   // register byte offsets on the wishbone slave
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_MAP = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_CONF_BIT = 2;
   localparam int CTRL_NJOBS_LSB = 4;
   localparam logic [1:0] CTRL_MODE_RST = 2'h0;
   localparam logic CTRL_CONF_RST = 1'b0;
   localparam logic [4:0] CTRL_NJOBS_RST = 5'h1f;
   localparam logic [31:0] MAP_RST = 32'h0000_0000;

   // status register fields
   localparam int STAT_ACTIVE_LSB = 0;
   localparam int STAT_SHOWN_LSB = 8;
   localparam int STAT_READY_BIT = 16;
   localparam int STAT_BUSY_BIT = 17;
   localparam int STAT_CONF_BIT = 18;

   // physical inputs and per-input function field
   localparam int NUM_INPUTS = 8;
   localparam int FN_W = 4;
   localparam int NUM_FN = 8;
   localparam int JOB_BITS = 5;

   // select schemes held in the mode field
   localparam logic [1:0] MODE_TWO_JOB = 2'h0;
   localparam logic [1:0] MODE_BINARY = 2'h1;
   localparam logic [1:0] MODE_PULSE = 2'h2;

   // input function codes
   localparam logic [3:0] FN_NONE = 4'h0;
   localparam logic [3:0] FN_JOB12 = 4'h1;
   localparam logic [3:0] FN_BIT0 = 4'h2;
   localparam logic [3:0] FN_PULSE = 4'h7;

   localparam logic [4:0] JOB_FIRST = 5'h01;
   localparam logic [4:0] JOB_SECOND = 5'h02;
   localparam logic [4:0] JOB_COUNT_MAX = 5'h1f;

   // timing
   localparam int CLK_KHZ = 200000;
   localparam int GAP_TIME_MS = 50;
   localparam int GAP_CYCLES = GAP_TIME_MS * CLK_KHZ;
   localparam int CONF_TIME_MS = 1;
   localparam int CONF_CYCLES = CONF_TIME_MS * CLK_KHZ;
   localparam int TIMER_W = 24;

   typedef enum logic [1:0] {
      PS_COUNT,
      PS_SWITCH,
      PS_CONFIRM
   } jsd_pulse_state_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [1:0] mode;
      logic conf_en;
      logic [4:0] njobs;
      logic [31:0] map;
      logic [4:0] pat;
      logic prev_pulse;
      logic [4:0] cnt;
      logic [23:0] timer;
      jsd_pulse_state_t pstate;
      logic busy;
      logic confirm;
      logic [4:0] job_num;
      logic load;
      logic [4:0] active;
      logic [4:0] shown;
      logic disp_pend;
   } jsd_state_t;

endpackage

/* dv/jsd_job_select_props.sv */
`timescale 1ns/1ps
`default_nettype none
module jsd_job_select_props #(
   parameter int unsigned CONF_CYCLES = 4
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic trigger_i,
   input wire logic job_loaded_i,
   input wire logic [4:0] job_num_o,
   input wire logic job_load_o,
   input wire logic ready_o,
   input wire logic confirm_o,
   input wire logic busy_o,
   input wire logic [4:0] active_job_o,
   input wire logic [4:0] shown_job_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   int unsigned conf_n;
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         conf_n <= 0;
      else
         conf_n <= confirm_o ? conf_n + 1 : 0;
   sequence s_done;
      busy_o && job_loaded_i;
   endsequence
   sequence s_idle;
      !busy_o && !job_load_o;
   endsequence
   property p_load; job_load_o |-> busy_o && job_num_o != 5'h00; endproperty
   a_load: assert property (p_load) else $error("bad load");
   property p_busy; $rose(busy_o) |-> job_load_o; endproperty
   a_busy: assert property (p_busy) else $error("busy without load");
   property p_done; s_done |=> s_idle ##0 active_job_o == $past(job_num_o); endproperty
   a_done: assert property (p_done) else $error("switch not finished");
   property p_rfall; $fell(ready_o) |-> job_load_o; endproperty
   a_rfall: assert property (p_rfall) else $error("ready fell alone");
   property p_crise; $rose(confirm_o) |-> $past(busy_o) && !busy_o && !ready_o; endproperty
   a_crise: assert property (p_crise) else $error("confirm early");
   property p_cend; $fell(confirm_o) |-> ready_o && conf_n == CONF_CYCLES; endproperty
   a_cend: assert property (p_cend) else $error("confirm end wrong");
   property p_shown; $changed(shown_job_o) |-> $past(trigger_i); endproperty
   a_shown: assert property (p_shown) else $error("shown moved alone");
   property p_show; trigger_i && !busy_o |=> shown_job_o == $past(active_job_o); endproperty
   a_show: assert property (p_show) else $error("shown not updated");
endmodule
bind jsd_job_select jsd_job_select_props #(.CONF_CYCLES(CONF_CYCLES)) u_props (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .trigger_i(trigger_i), .job_loaded_i(job_loaded_i),
   .job_num_o(job_num_o), .job_load_o(job_load_o), .ready_o(ready_o), .confirm_o(confirm_o),
   .busy_o(busy_o), .active_job_o(active_job_o), .shown_job_o(shown_job_o));
`default_nettype wire

/* dv/jsd_plc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module jsd_plc_model (
   input wire logic clk_i,
   input wire logic busy_i,
   output logic [7:0] din_o,
   output logic loaded_o
);
   int lat = 2;
   // loader takes lat cycles so busy is seen to stand
   initial begin
      din_o = 8'h00;
      loaded_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (busy_i === 1'b1) begin
            repeat (lat) @(posedge clk_i);
            loaded_o <= 1'b1;
            @(posedge clk_i);
            loaded_o <= 1'b0;
            @(posedge clk_i);
         end
      end
   end
   task automatic set_pat(input logic [7:0] v);
      @(posedge clk_i);
      din_o <= v;
   endtask
   // two cycles high, two low: scaled like the gap
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_i);
         din_o[0] <= 1'b1;
         repeat (2) @(posedge clk_i);
         din_o[0] <= 1'b0;
         @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int GAP = 20;
   logic clk_i, reset_n_i, cyc, stb, we, trig, ack, load, rdy, conf, busy, loaded;
   logic [3:0] adr;
   logic [31:0] wdat, rd, dat, v, prev;
   logic [4:0] num, act, shown;
   logic [7:0] din;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int n_compared = 0;
   int cnt;
   int np[3] = '{3, 20, 21};
   jsd_job_select #(.GAP_CYCLES(GAP), .CONF_CYCLES(4)) u_dut (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .din_i(din),
      .trigger_i(trig), .job_loaded_i(loaded), .job_num_o(num), .job_load_o(load),
      .ready_o(rdy), .confirm_o(conf), .busy_o(busy), .active_job_o(act), .shown_job_o(shown));
   jsd_plc_model plc (.clk_i(clk_i), .busy_i(busy), .din_o(din), .loaded_o(loaded));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, want);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      rd = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_i);
      while (busy !== 1'b0)
         @(posedge clk_i);
   endtask
   always @(posedge clk_i)
      if (load === 1'b1)
         chk({27'h0, num}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hff);
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      v = $urandom(32'h3fd12e95);
      {reset_n_i, cyc, stb, we, trig} = 5'h00;
      adr = 4'h0;
      wdat = 32'h0;
      prev = 32'h0;
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      chk({26'h0, rdy, act}, 32'h21);
      wb(1'b0, jsd_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h1f0);
      wb(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, jsd_pkg::ADDR_MAP, 32'h1000);
      for (int i = 2; i > 0; i--) begin
         exp_q.push_back(32'(i));
         plc.set_pat(i == 2 ? 8'h08 : 8'h00);
         settle();
      end
      wb(1'b1, jsd_pkg::ADDR_MAP, 32'h6543_2000);
      wb(1'b1, jsd_pkg::ADDR_CTRL, 32'h141);
      for (int i = 0; i < 8; i++) begin
         v = i < 5 ? $urandom_range(19, 1) : i == 5 ? 20 : i == 6 ? 0 : 21;
         if (v == prev)
            v = v ^ 32'h1;
         if (v != 0 && v <= 20)
            exp_q.push_back(v);
         plc.lat = $urandom_range(5, 1);
         plc.set_pat({v[4:0], 3'h0});
         settle();
         prev = v;
      end
      chk({27'h0, shown}, 32'h1);
      @(posedge clk_i);
      trig <= 1'b1;
      @(posedge clk_i);
      trig <= 1'b0;
      @(posedge clk_i);
      chk({22'h0, shown, act}, 32'h294);
      plc.set_pat(8'h00);
      wb(1'b1, jsd_pkg::ADDR_MAP, 32'h7);
      wb(1'b1, jsd_pkg::ADDR_CTRL, 32'h146);
      foreach (np[k]) begin
         if (np[k] <= 20)
            exp_q.push_back(np[k]);
         plc.pulses(np[k]);
         cnt = 0;
         while (rdy === 1'b1 && cnt < GAP + 8) begin
            @(posedge clk_i);
            cnt++;
         end
         chk(32'(np[k] > 20 ? cnt == GAP + 8 : cnt >= GAP - 4 && cnt <= GAP), 32'h1);
         if (np[k] <= 20)
            plc.pulses(1);
         while (rdy !== 1'b1)
            @(posedge clk_i);
         chk({27'h0, act}, np[k] > 20 ? 32'd20 : np[k]);
      end
      repeat (GAP + 10) @(posedge clk_i);
      wb(1'b0, jsd_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h0001_1414);
      chk(exp_q.size(), 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
